/* File: core/adg_pin_mux.sv */
`timescale 1ns/1ps
module adg_pin_mux #(
   parameter int NUM_PINS = 2
) (
   // Miscellaneous control
   input wire logic ready_en,
   input wire logic ready_pol,
   input wire logic ready_sel,
   input wire logic sample_ready,
   // Alarm claims
   input wire logic [NUM_PINS-1:0] alarm_own,
   input wire logic [NUM_PINS-1:0] alarm_level,
   // Pin control register fields
   input wire logic [NUM_PINS-1:0] pin_dir,
   input wire logic [NUM_PINS-1:0] pin_level,
   // Resolved pin drive
   output logic [NUM_PINS-1:0] drive,
   output logic [NUM_PINS-1:0] level
);
   logic ready_level;

   assign ready_level = ready_pol ? sample_ready : ~sample_ready;

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      logic misc_own;
      assign misc_own = ready_en && (ready_sel == 1'(i));
      always_comb begin
         if (misc_own) begin
            drive[i] = 1'b1;
            level[i] = ready_level;
         end else if (alarm_own[i]) begin
            drive[i] = 1'b1;
            level[i] = alarm_level[i];
         end else begin
            drive[i] = pin_dir[i];
            level[i] = pin_dir[i] & pin_level[i];
         end
      end
   end
endmodule

/* File: core/adg_pkg.sv */
package adg_pkg;
   // Byte addresses of the register port
   localparam logic [7:0] ADG_ADDR_CODE_LO = 8'h30;
   localparam logic [7:0] ADG_ADDR_CODE_HI = 8'h31;
   localparam logic [7:0] ADG_ADDR_PIN_LO = 8'h32;
   localparam logic [7:0] ADG_ADDR_PIN_HI = 8'h33;
   localparam logic [7:0] ADG_ADDR_MISC_LO = 8'h34;
   localparam logic [7:0] ADG_ADDR_MISC_HI = 8'h35;
   localparam logic [7:0] ADG_ADDR_CMD_LO = 8'h3E;
   localparam logic [7:0] ADG_ADDR_CMD_HI = 8'h3F;
   // Reset values
   localparam logic [15:0] ADG_CODE_RESET = 16'h0000;
   localparam logic [15:0] ADG_PIN_RESET = 16'h0000;
   localparam logic [15:0] ADG_MISC_RESET = 16'h0000;
   // Implemented bits of each register
   localparam logic [15:0] ADG_CODE_MASK = 16'h0FFF;
   localparam logic [15:0] ADG_PIN_MASK = 16'h0303;
   localparam logic [15:0] ADG_MISC_MASK = 16'h0707;
   // Field positions
   localparam int ADG_CODE_WIDTH = 12;
   localparam int ADG_CMD_LATCH_BIT = 2;
   localparam int ADG_PIN_DIR_LSB = 0;
   localparam int ADG_PIN_LEVEL_LSB = 8;
   localparam int ADG_MISC_READY_EN_BIT = 2;
   localparam int ADG_MISC_READY_POL_BIT = 1;
   localparam int ADG_MISC_READY_SEL_BIT = 0;
   localparam int ADG_NUM_PINS = 2;
endpackage

/* File: core/adg_regs.sv */
`timescale 1ns/1ps
module adg_regs #(
   parameter int NUM_PINS = adg_pkg::ADG_NUM_PINS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Byte register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Device events and alarm claims
   input wire logic sample_ready,
   input wire logic [NUM_PINS-1:0] alarm_own,
   input wire logic [NUM_PINS-1:0] alarm_level,
   // Converter
   output logic [adg_pkg::ADG_CODE_WIDTH-1:0] dac_code,
   // Pins
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe_n
);
   import adg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   typedef struct packed {
      // Bytes as written with the top four bits dropped, kept off the converter
      logic [15:0] code_hold;
      // Code the converter is driven with
      logic [ADG_CODE_WIDTH-1:0] code_out;
      // Directions in the low byte, levels in the high byte
      logic [15:0] pin_ctrl;
      // Ready routing; upper stored bits drive nothing here
      logic [15:0] misc;
      // Read byte, stands until the next read
      logic [7:0] rdata;
      // Pin drive registered so pins never glitch
      logic [NUM_PINS-1:0] pin_out;
      logic [NUM_PINS-1:0] pin_oe_n;
   } adg_state_t;

   // Reset image: registers at their defaults, pins released as inputs
   localparam adg_state_t ADG_ST_RESET = '{
      code_hold: ADG_CODE_RESET,
      code_out: ADG_CODE_RESET[ADG_CODE_WIDTH-1:0],
      pin_ctrl: ADG_PIN_RESET,
      misc: ADG_MISC_RESET,
      rdata: 8'h00,
      pin_out: '0,
      pin_oe_n: '1
   };

   adg_state_t st_q;
   adg_state_t st_d;
   logic [NUM_PINS-1:0] mux_drive;
   logic [NUM_PINS-1:0] mux_level;
   logic byte_hi;
   logic hit_code;
   logic hit_pin;
   logic hit_misc;
   logic hit_latch;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   // Odd address selects the upper byte of a register
   assign byte_hi = reg_addr[0];
   assign hit_code = (reg_addr == ADG_ADDR_CODE_LO) ||
                     (reg_addr == ADG_ADDR_CODE_HI);
   assign hit_pin = (reg_addr == ADG_ADDR_PIN_LO) ||
                    (reg_addr == ADG_ADDR_PIN_HI);
   assign hit_misc = (reg_addr == ADG_ADDR_MISC_LO) ||
                     (reg_addr == ADG_ADDR_MISC_HI);
   // Only the even command byte acts; the odd one stores nothing
   // Latch bit tested here; the write strobe still gates it below
   assign hit_latch = (reg_addr == ADG_ADDR_CMD_LO) && reg_wdata[ADG_CMD_LATCH_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Pin ownership and drive resolution
   adg_pin_mux #(
      .NUM_PINS(NUM_PINS)
   ) u_mux (
      .ready_en(st_q.misc[ADG_MISC_READY_EN_BIT]),
      .ready_pol(st_q.misc[ADG_MISC_READY_POL_BIT]),
      .ready_sel(st_q.misc[ADG_MISC_READY_SEL_BIT]),
      .sample_ready(sample_ready),
      .alarm_own(alarm_own),
      .alarm_level(alarm_level),
      .pin_dir(st_q.pin_ctrl[ADG_PIN_DIR_LSB +: NUM_PINS]),
      .pin_level(st_q.pin_ctrl[ADG_PIN_LEVEL_LSB +: NUM_PINS]),
      .drive(mux_drive),
      .level(mux_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Byte merge: low byte at even address, high byte at odd address
   function automatic logic [15:0] merge_byte(
      input logic [15:0] cur,
      input logic hi,
      input logic [7:0] data,
      input logic [15:0] mask
   );
      logic [15:0] res;
      res = cur;
      if (hi) begin
         res[15:8] = data;
      end else begin
         res[7:0] = data;
      end
      return res & mask;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   // Bits never stored read back as zero
   function automatic logic [7:0] read_byte(
      input logic [7:0] addr,
      input logic [15:0] code,
      input logic [15:0] pin,
      input logic [15:0] misc
   );
      logic [7:0] res;
      unique case (addr)
         ADG_ADDR_CODE_LO: begin
            res = code[7:0];
         end
         ADG_ADDR_CODE_HI: begin
            res = code[15:8];
         end
         ADG_ADDR_PIN_LO: begin
            res = pin[7:0];
         end
         ADG_ADDR_PIN_HI: begin
            res = pin[15:8];
         end
         ADG_ADDR_MISC_LO: begin
            res = misc[7:0];
         end
         ADG_ADDR_MISC_HI: begin
            res = misc[15:8];
         end
         // Command bytes and unmapped addresses read zero
         default: begin
            res = 8'h00;
         end
      endcase
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_d = st_q;
      if (reg_wr) begin
         // code bytes only reach the holding register; pin and misc bytes apply directly
         if (hit_code) begin
            st_d.code_hold = merge_byte(st_q.code_hold, byte_hi, reg_wdata, ADG_CODE_MASK);
         end
         if (hit_pin) begin
            st_d.pin_ctrl = merge_byte(st_q.pin_ctrl, byte_hi, reg_wdata, ADG_PIN_MASK);
         end
         if (hit_misc) begin
            st_d.misc = merge_byte(st_q.misc, byte_hi, reg_wdata, ADG_MISC_MASK);
         end
         // latch both held bytes at once
         // Held bytes move together, so the converter never sees half a code
         if (hit_latch) begin
            st_d.code_out = st_q.code_hold[ADG_CODE_WIDTH-1:0];
         end
         // Unmapped addresses fall through and change nothing
      end
      // Read data registered one cycle after the strobe
      // A read in the cycle of a write returns the old value
      if (reg_rd) begin
         st_d.rdata = read_byte(reg_addr, st_q.code_hold, st_q.pin_ctrl, st_q.misc);
      end
      // pins registered so outputs come from flops
      // Costs one cycle of latency on every pin change
      st_d.pin_out = mux_level;
      st_d.pin_oe_n = ~mux_drive;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         // pins cleared to inputs
         // Pins leave reset released, so nothing fights the board
         st_q <= ADG_ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Every output is a flop, so no input reaches a pin in the same cycle
   assign reg_rdata = st_q.rdata;
   assign dac_code = st_q.code_out;
   assign pin_out = st_q.pin_out;
   assign pin_oe_n = st_q.pin_oe_n;
endmodule

/* File: tb/adg_chk.sv */
`timescale 1ns/1ps
module adg_chk #(
   parameter int NUM_PINS = 2
) (
   // Clock, reset, register port
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Claims and outputs
   input wire logic [NUM_PINS-1:0] alarm_own,
   input wire logic [adg_pkg::ADG_CODE_WIDTH-1:0] dac_code,
   input wire logic [NUM_PINS-1:0] pin_out,
   input wire logic [NUM_PINS-1:0] pin_oe_n
);
   import adg_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_code_held: assert property (!$stable(dac_code) |->
      $past(reg_wr && reg_addr == 8'h3E && reg_wdata[2])) else $error("code moved");
   a_code_top: assert property (reg_rd && reg_addr == 8'h31 |=>
      reg_rdata[7:4] == 4'h0) else $error("code top");
   a_pin_top: assert property (reg_rd && reg_addr == 8'h33 |=>
      reg_rdata[7:2] == 6'h00) else $error("pin top");
   a_pin_low: assert property (reg_rd && reg_addr == 8'h32 |=>
      reg_rdata[7:2] == 6'h00) else $error("pin low");
   a_misc_top: assert property (reg_rd && reg_addr == 8'h35 |=>
      reg_rdata[7:3] == 5'h00) else $error("misc top");
   a_input_quiet: assert property ((pin_out & pin_oe_n) == '0)
      else $error("input driven");
   a_alarm_drives: assert property (alarm_own != '0 |=>
      (pin_oe_n & $past(alarm_own)) == '0) else $error("alarm pin");
   a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("rdata moved");
endmodule

/* File: tb/adg_host.sv */
`timescale 1ns/1ps
module adg_host (
   // Register port
   input wire logic clk,
   output logic [7:0] reg_addr = 8'h00,
   output logic reg_wr = 1'b0,
   output logic [7:0] reg_wdata = 8'h00,
   output logic reg_rd = 1'b0,
   input wire logic [7:0] reg_rdata
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk);
      // Released lines flip so a stale byte never looks valid
      {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk);
      {reg_addr, reg_rd} = {~a, 1'b0};
      d = reg_rdata;
   endtask
endmodule

/* File: tb/aux_dac_gpio_control_test.sv */
`timescale 1ns/1ps
module aux_dac_gpio_control_test;
   import adg_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic sample_ready = 1'b0;
   logic [1:0] alarm_own = 2'h0;
   logic [1:0] alarm_level = 2'h0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic reg_wr, reg_rd;
   logic [ADG_CODE_WIDTH-1:0] dac_code;
   logic [1:0] pin_out, pin_oe_n;
   int n_fail = 0;
   int comparisons = 0;
   always #5 clk = ~clk;
   adg_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   adg_regs i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_ready(sample_ready),
      .alarm_own(alarm_own), .alarm_level(alarm_level), .dac_code(dac_code),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n));
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, rv);
      chk("rdata", {8'h00, rv}, {8'h00, e});
   endtask
   task automatic pc(input logic [3:0] e);
      @(negedge clk);
      chk("oe_n,out", {12'h000, pin_oe_n, pin_out}, {12'h000, e});
   endtask
   task automatic close_out;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      close_out;
   end
   initial begin
      repeat (2) @(negedge clk);
      reset = 1'b0;
      rc(8'h30, 8'h00);
      rc(8'h32, 8'h00);
      pc(4'hC);
      i_host.wr(8'h30, 8'h34);
      i_host.wr(8'h31, 8'hF2);
      chk("dac", {4'h0, dac_code}, 16'h0000);
      rc(8'h31, 8'h02);
      i_host.wr(8'h3E, 8'h04);
      @(negedge clk);
      chk("dac", {4'h0, dac_code}, 16'h0234);
      i_host.wr(8'h30, 8'hFF);
      i_host.wr(8'h31, 8'hFF);
      i_host.wr(8'h3E, 8'h00);
      @(negedge clk);
      chk("dac", {4'h0, dac_code}, 16'h0234);
      i_host.wr(8'h3E, 8'h04);
      @(negedge clk);
      chk("dac", {4'h0, dac_code}, 16'h0FFF);
      i_host.wr(8'h32, 8'hFF);
      i_host.wr(8'h33, 8'h02);
      pc(4'h2);
      rc(8'h32, 8'h03);
      alarm_own = 2'h2;
      pc(4'h0);
      sample_ready = 1'b1;
      i_host.wr(8'h34, 8'h07);
      pc(4'h2);
      i_host.wr(8'h34, 8'h05);
      pc(4'h0);
      rc(8'h35, 8'h00);
      i_host.wr(8'h33, 8'h01);
      i_host.wr(8'h32, 8'h02);
      pc(4'h4);
      rc(8'h33, 8'h01);
      i_host.wr(8'h34, 8'h06);
      pc(4'h1);
      alarm_level = 2'h2;
      sample_ready = 1'b0;
      pc(4'h2);
      alarm_own = 2'h1;
      alarm_level = 2'h1;
      i_host.wr(8'h34, 8'h00);
      pc(4'h1);
      reset = 1'b1;
      @(negedge clk);
      reset = 1'b0;
      pc(4'h9);
      rc(8'h33, 8'h00);
      chk("dac", {4'h0, dac_code}, 16'h0000);
      close_out;
   end
endmodule
bind adg_regs adg_chk #(.NUM_PINS(NUM_PINS)) i_chk (.clk(clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .alarm_own(alarm_own), .dac_code(dac_code), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n));
